/* logic/smbus_block_write_config.sv */
// configuration port and output enable timing of a twelve-output clock buffer
// Behaviour
// - the device acknowledges its address, the index byte and the count byte on the ninth clock.
// - X data bytes are stored at N..N+X-1, each acknowledged.
// - a pair starts or stops 4 to 12 output clock cycles after its enable pin changes.
// - outputs are driven again within 300 us after power-down release.
// - the first output clock appears within 1.8 ms after power-up or power-down release.
// - a three-level address select picks one of three slave addresses.
// - a pair runs only when its register bit is one and its enable pin is zero.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_consts.svh"
module smbus_block_write_config #(
    parameter int NUM_PAIRS = 12,
    parameter int DRIVE_PD_CYC = `DRIVE_PD_US * `SYS_CLK_MHZ,
    parameter int STAB_CYC = `STAB_US * `SYS_CLK_MHZ
) (
    // system
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // smbus pins
    input wire logic i_smb_clk,
    input wire logic i_smb_dat,
    output logic o_smb_dat,
    output logic o_smb_dat_oe,
    input wire cfg_pkg::addr_sel_type i_addr_sel,
    // differential input clock (link domain)
    input wire logic i_ref_clk,
    // output control
    input wire logic [NUM_PAIRS-1:0] i_pair_enable_n,
    input wire logic i_power_down_request,
    output logic [NUM_PAIRS-1:0] o_clock_output_pair,
    output logic [NUM_PAIRS-1:0] o_clock_output_pair_oe
);
    import cfg_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic [1:0] pd_sync_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            pd_sync_reg <= 2'h3;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], i_smb_clk};
            sda_sync_reg <= {sda_sync_reg[1:0], i_smb_dat};
            pd_sync_reg <= {pd_sync_reg[0], i_power_down_request};
        end
    end
    // only stages 1 and 2 feed logic; stage 0 goes nowhere else
    wire scl = scl_sync_reg[1];
    wire scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
    wire scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
    wire sda = sda_sync_reg[1];
    wire start_cond = scl && scl_sync_reg[2] && !sda_sync_reg[1] && sda_sync_reg[2];
    wire stop_cond = scl && scl_sync_reg[2] && sda_sync_reg[1] && !sda_sync_reg[2];

    // strap and enable pins pass two stages; the strap is static, so a torn code is harmless
    addr_sel_type sel_sync0_reg;
    addr_sel_type sel_sync1_reg;
    logic [NUM_PAIRS-1:0] pin_sync0_reg;
    logic [NUM_PAIRS-1:0] pin_sync1_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sel_sync0_reg <= ADDR_SEL_LOW;
            sel_sync1_reg <= ADDR_SEL_LOW;
            pin_sync0_reg <= '1;
            pin_sync1_reg <= '1;
        end
        else
        begin
            sel_sync0_reg <= i_addr_sel;
            sel_sync1_reg <= sel_sync0_reg;
            pin_sync0_reg <= i_pair_enable_n;
            pin_sync1_reg <= pin_sync0_reg;
        end
    end

    function automatic logic [6:0] own_addr(input addr_sel_type sel);
        unique case (sel)
            ADDR_SEL_MID: own_addr = `ADDR_SEL_MID;
            ADDR_SEL_HIGH: own_addr = `ADDR_SEL_HIGH;
            default: own_addr = `ADDR_SEL_LOW;
        endcase
    endfunction

    // ----------------------------------------
    // smbus block write receiver
    // ----------------------------------------
    bus_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] index_reg;
    logic [7:0] count_reg;
    logic ack_reg;
    logic [7:0] regs_reg [`REG_COUNT];
    wire byte_done = scl_rise && bit_cnt_reg == 4'h7;
    wire [7:0] byte_in = {shift_reg[6:0], sda};

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            index_reg <= 8'h00;
            count_reg <= 8'h00;
            ack_reg <= 1'b0;
        end
        else if (start_cond)
        begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
        end
        else if (stop_cond)
        begin
            state_reg <= ST_IDLE;
            ack_reg <= 1'b0;
        end
        else if (state_reg != ST_IDLE && state_reg != ST_SKIP)
        begin
            if (scl_rise && bit_cnt_reg < 4'h8)
                shift_reg <= byte_in;
            if (scl_rise)
                bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
            if (scl_fall && bit_cnt_reg == 4'h8)
                ack_reg <= 1'b1; // drive low through the ninth clock
            if (scl_fall && bit_cnt_reg == 4'h0)
                ack_reg <= 1'b0;
            if (byte_done)
            begin
                unique case (state_reg)
                    ST_ADDR:
                        if (byte_in[7:1] == own_addr(sel_sync1_reg) && !byte_in[0])
                            state_reg <= ST_INDEX;
                        else
                            state_reg <= ST_SKIP;
                    ST_INDEX:
                    begin
                        index_reg <= byte_in;
                        state_reg <= ST_COUNT;
                    end
                    ST_COUNT:
                    begin
                        count_reg <= byte_in;
                        state_reg <= ST_DATA;
                    end
                    // a spent count stays at zero, so surplus bytes never land
                    default:
                        if (count_reg != 8'h00)
                        begin
                            index_reg <= index_reg + 8'h01;
                            count_reg <= count_reg - 8'h01;
                        end
                endcase
            end
        end
    end
    // an address mismatch jumps to skip before the ninth clock, so no ack goes out
    assign o_smb_dat = 1'b0;
    assign o_smb_dat_oe = ack_reg && state_reg != ST_SKIP && state_reg != ST_IDLE;

    // storage; bytes beyond the count or map are dropped but still acknowledged
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int i = 0; i < `REG_COUNT; i++)
                regs_reg[i] <= (i == 1 || i == 2) ? `OUT_CTRL_RESET : 8'h00;
        end
        else if (byte_done && state_reg == ST_DATA && count_reg != 8'h00
                 && index_reg < 8'(`REG_COUNT))
            regs_reg[index_reg[2:0]] <= byte_in;
    end

    // ----------------------------------------
    // power-down and stabilisation timer
    // ----------------------------------------
    // the shorter of the two limits governs release, so counting 1.8 ms after
    // release would break the 300 us figure; release uses its own shorter count
    logic [31:0] stab_cnt_reg;
    logic powered_reg;
    logic first_done_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            stab_cnt_reg <= 32'h0;
            powered_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end
        else if (pd_sync_reg[1])
        begin
            stab_cnt_reg <= 32'h0;
            powered_reg <= 1'b0;
        end
        else if (!powered_reg)
        begin
            stab_cnt_reg <= stab_cnt_reg + 32'h1;
            if (stab_cnt_reg >= 32'(first_done_reg ? DRIVE_PD_CYC - 1 : STAB_CYC - 1))
            begin
                powered_reg <= 1'b1;
                first_done_reg <= 1'b1;
            end
        end
    end

    // enable request per pair in system domain
    logic [NUM_PAIRS-1:0] want_reg;
    wire [15:0] ctrl_bits = {regs_reg[`OUT_CTRL_HI_IDX], regs_reg[`OUT_CTRL_LO_IDX]};
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            want_reg <= '0;
        else
            want_reg <= ctrl_bits[NUM_PAIRS-1:0] & ~pin_sync1_reg
                        & {NUM_PAIRS{powered_reg}};
    end

    // ----------------------------------------
    // output clock domain
    // ----------------------------------------
    logic ref_rst_sync_reg;
    logic ref_rst_b_reg;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ref_rst_sync_reg <= 1'b0;
            ref_rst_b_reg <= 1'b0;
        end
        else
        begin
            ref_rst_sync_reg <= 1'b1;
            ref_rst_b_reg <= ref_rst_sync_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++)
        begin : g_pair
            logic [`OE_LAT_USED_CYC-1:0] dly_reg;
            logic run_reg;
            // two stages synchronise, the rest pad latency into the 4..12 window
            always_ff @(posedge i_ref_clk or negedge ref_rst_b_reg)
            begin
                if (!ref_rst_b_reg)
                begin
                    dly_reg <= '0;
                    run_reg <= 1'b0;
                end
                else
                begin
                    dly_reg <= {dly_reg[`OE_LAT_USED_CYC-2:0], want_reg[g]};
                    run_reg <= dly_reg[`OE_LAT_USED_CYC-1];
                end
            end
            logic tog_reg;
            always_ff @(posedge i_ref_clk or negedge ref_rst_b_reg)
            begin
                if (!ref_rst_b_reg)
                    tog_reg <= 1'b0;
                else
                    tog_reg <= run_reg ? ~tog_reg : 1'b0;
            end
            assign o_clock_output_pair[g] = tog_reg;
            assign o_clock_output_pair_oe[g] = run_reg;
        end
    endgenerate
endmodule
`default_nettype wire

/* logic/cfg_consts.svh */
// constants for the configuration port and output timing
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH
`define ADDR_SEL_LOW 7'h6e
`define ADDR_SEL_MID 7'h6b
`define ADDR_SEL_HIGH 7'h6a
`define REG_COUNT 8
`define OUT_CTRL_LO_IDX 3'h1
`define OUT_CTRL_HI_IDX 3'h2
`define OUT_CTRL_RESET 8'hff
`define OE_LAT_MIN_CYC 4
`define OE_LAT_MAX_CYC 12
`define OE_LAT_USED_CYC 6
`define DRIVE_PD_US 300
`define STAB_US 1800
`define SYS_CLK_MHZ 250
`endif

/* logic/cfg_pkg.sv */
// types for the configuration port
package cfg_pkg;
    typedef enum logic [1:0] {ADDR_SEL_LOW, ADDR_SEL_MID, ADDR_SEL_HIGH} addr_sel_type;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_DATA, ST_SKIP} bus_state_type;
endpackage

/* bench/smbus_block_write_config_asserts.sv */
// assertion checker for the configuration port and pair enable timing
`timescale 1ns/100ps
`default_nettype none
module smbus_cfg_asserts #(parameter int NUM_PAIRS = 12) (
    // watched ports
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_smb_clk,
    input wire logic i_smb_dat,
    input wire logic o_smb_dat,
    input wire logic o_smb_dat_oe,
    input wire cfg_pkg::addr_sel_type i_addr_sel,
    input wire logic i_ref_clk,
    input wire logic [NUM_PAIRS-1:0] i_pair_enable_n,
    input wire logic i_power_down_request,
    input wire logic [NUM_PAIRS-1:0] o_clock_output_pair,
    input wire logic [NUM_PAIRS-1:0] o_clock_output_pair_oe
);
    import cfg_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_open_drain; o_smb_dat == 1'b0; endproperty
    property p_ack_rise; $rose(o_smb_dat_oe) |-> !i_smb_clk; endproperty
    property p_ack_hold; $rose(o_smb_dat_oe) |-> o_smb_dat_oe [*8]; endproperty
    property p_ack_fall; $fell(o_smb_dat_oe) |-> !i_smb_clk; endproperty
    property p_en_min;
        $fell(i_pair_enable_n[0]) && !o_clock_output_pair_oe[0]
            |-> ##1 (!o_clock_output_pair_oe[0]) [*4];
    endproperty
    property p_en_max;
        $fell(i_pair_enable_n[0]) && !i_power_down_request
            |-> ##[1:60] o_clock_output_pair_oe[0];
    endproperty
    property p_dis_max;
        $rose(i_pair_enable_n[0]) |-> ##[1:60] !o_clock_output_pair_oe[0];
    endproperty
    // toggles on every rising ref edge, so any four sys cycles see a change
    property p_toggle;
        o_clock_output_pair_oe[0] [*3] |-> ##[0:3] $changed(o_clock_output_pair[0]);
    endproperty
    property p_pd_off;
        $rose(i_power_down_request) |-> ##[1:60] o_clock_output_pair_oe == '0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    a_ack_rise: assert property (p_ack_rise) else $error("ack rose with clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
    a_ack_fall: assert property (p_ack_fall) else $error("ack fell with clock high");
    a_en_min: assert property (p_en_min) else $error("pair started too early");
    a_en_max: assert property (p_en_max) else $error("pair started too late");
    a_dis_max: assert property (p_dis_max) else $error("pair stopped too late");
    a_toggle: assert property (p_toggle) else $error("enabled pair not toggling");
    a_pd_off: assert property (p_pd_off) else $error("pairs driven in power down");
    c_ack: cover property ($rose(o_smb_dat_oe));
    c_pin: cover property ($fell(i_pair_enable_n[0]));
    c_pd: cover property ($fell(i_power_down_request));
endmodule
bind smbus_block_write_config smbus_cfg_asserts #(.NUM_PAIRS(NUM_PAIRS)) chk_u (
    .i_sys_clk, .i_rst_b, .i_smb_clk, .i_smb_dat, .o_smb_dat, .o_smb_dat_oe,
    .i_addr_sel, .i_ref_clk, .i_pair_enable_n, .i_power_down_request,
    .o_clock_output_pair, .o_clock_output_pair_oe
);
`default_nettype wire

/* bench/smb_host_model.sv */
// bus host model driving block writes over the open-drain pins
`timescale 1ns/100ps
`default_nettype none
module smb_host_model (
    // clock and bus
    input wire logic i_sys_clk,
    input wire logic i_dev_pull,
    output logic o_smb_clk,
    output logic o_smb_dat
);
    logic drive_low = 1'b0;
    initial o_smb_clk = 1'b1;
    // pull-up: high unless a party pulls it
    assign o_smb_dat = !(drive_low || i_dev_pull);
    task automatic half();
        repeat (10) @(posedge i_sys_clk);
        #1;
    endtask
    // data moves only in the low phase, held a half period each side
    task automatic pulse(output logic s);
        half();
        o_smb_clk = 1'b1;
        half();
        s = o_smb_dat;
        o_smb_clk = 1'b0;
        half();
    endtask
    task automatic start();
        drive_low = 1'b0;
        half();
        o_smb_clk = 1'b1;
        half();
        drive_low = 1'b1;
        half();
        o_smb_clk = 1'b0;
        half();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            drive_low = !b[i];
            pulse(s);
        end
        drive_low = 1'b0;
        pulse(s);
        ack = !s;
    endtask
    task automatic stop();
        drive_low = 1'b1;
        half();
        o_smb_clk = 1'b1;
        half();
        drive_low = 1'b0;
        half();
    endtask
endmodule
`default_nettype wire

/* bench/smbus_block_write_config_test.sv */
// self-checking bench for the configuration port
`timescale 1ns/100ps
`default_nettype none
module smbus_block_write_config_test;
    import cfg_pkg::*;
    typedef struct {addr_sel_type sel; logic [7:0] addr; logic ack;} row_type;
    row_type rows [6] = '{'{ADDR_SEL_LOW, 8'hdc, 1'b1}, '{ADDR_SEL_MID, 8'hd6, 1'b1},
        '{ADDR_SEL_HIGH, 8'hd4, 1'b1}, '{ADDR_SEL_LOW, 8'hd6, 1'b0},
        '{ADDR_SEL_MID, 8'hd4, 1'b0}, '{ADDR_SEL_LOW, 8'hdd, 1'b0}};
    logic [7:0] wr [6] = '{8'hdc, 8'h01, 8'h02, 8'h01, 8'h0e, 8'h55};
    // count zero: every data byte after it is surplus and must land nowhere
    logic [7:0] wr2 [5] = '{8'hdc, 8'h01, 8'h00, 8'h00, 8'h00};
    logic i_sys_clk, i_rst_b, i_ref_clk, pd, smb_clk, smb_dat, dev_pull, ack;
    logic [11:0] pins, pair, pair_oe;
    addr_sel_type sel;
    int err_total, cmp_count;
    smbus_block_write_config #(.DRIVE_PD_CYC(20), .STAB_CYC(40)) dut_u (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_smb_clk(smb_clk), .i_smb_dat(smb_dat),
        .o_smb_dat(), .o_smb_dat_oe(dev_pull), .i_addr_sel(sel), .i_ref_clk(i_ref_clk),
        .i_pair_enable_n(pins), .i_power_down_request(pd), .o_clock_output_pair(pair),
        .o_clock_output_pair_oe(pair_oe));
    smb_host_model host_u (.i_sys_clk(i_sys_clk), .i_dev_pull(dev_pull),
        .o_smb_clk(smb_clk), .o_smb_dat(smb_dat));
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = !i_sys_clk;
    end
    // link clock, phase unrelated to the system clock
    initial
    begin
        i_ref_clk = 1'b0;
        #1.3;
        forever #3 i_ref_clk = !i_ref_clk;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic check_ack(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected ack at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_oe(input logic [11:0] exp);
        cmp_count++;
        if (pair_oe !== exp)
        begin
            err_total++;
            $display("unexpected enables at %0t got %h exp %h", $time, pair_oe, exp);
        end
    endtask
    // a running pair flips once per link clock, so two looks one link period apart differ
    task automatic check_tog(input logic [11:0] exp);
        logic [11:0] seen;
        seen = pair;
        #6;
        cmp_count++;
        if ((seen ^ pair) !== exp)
        begin
            err_total++;
            $display("unexpected toggles at %0t got %h exp %h", $time, seen ^ pair, exp);
        end
        wait_cyc(1);
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        i_rst_b = 1'b0;
        pd = 1'b0;
        pins = 12'h000;
        sel = ADDR_SEL_LOW;
        wait_cyc(3);
        i_rst_b = 1'b1;
        wait_cyc(100);
        check_oe(12'hfff);
        check_tog(12'hfff);
        foreach (rows[i])
        begin
            sel = rows[i].sel;
            host_u.start();
            host_u.send_byte(rows[i].addr, ack);
            host_u.stop();
            check_ack(ack, rows[i].ack);
        end
        // index 1, count 2, one surplus byte that must not land
        host_u.start();
        foreach (wr[i])
        begin
            host_u.send_byte(wr[i], ack);
            check_ack(ack, 1'b1);
        end
        host_u.stop();
        wait_cyc(100);
        check_oe({wr[4][3:0], wr[3]});
        host_u.start();
        foreach (wr2[i])
        begin
            host_u.send_byte(wr2[i], ack);
            check_ack(ack, 1'b1);
        end
        host_u.stop();
        wait_cyc(100);
        check_oe(12'he01);
        pins[0] = 1'b1;
        wait_cyc(60);
        check_oe(12'he00);
        pins[0] = 1'b0;
        wait_cyc(60);
        check_oe(12'he01);
        check_tog(12'he01);
        pd = 1'b1;
        wait_cyc(100);
        check_oe(12'h000);
        check_tog(12'h000);
        pd = 1'b0;
        wait_cyc(100);
        check_oe(12'he01);
        finish_test();
    end
    // whole run needs about 23 us
    initial
    begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
